// file: hw/tap_pkg.sv
// Shared constants and types for the serial boundary-scan test port.
// Assumes one system clock domain; test pins arrive asynchronously.
package tap_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // Widths
    localparam int unsigned IR_W = 3;
    localparam int unsigned BSR_LEN = 107;
    localparam int unsigned ID_W = 32;
    localparam int unsigned PIN_W = 3;

    ////////////////////////////////////////////////////////////////////////////
    // Instruction codes
    localparam logic [IR_W-1:0] INS_EXTEST = 3'h0;
    localparam logic [IR_W-1:0] INS_IDCODE = 3'h1;
    localparam logic [IR_W-1:0] INS_SAMPLE_Z = 3'h2;
    localparam logic [IR_W-1:0] INS_SAMPLE = 3'h4;
    localparam logic [IR_W-1:0] INS_BYPASS = 3'h7;

    // Fixed pattern for the two low bits in Capture-IR
    localparam logic [1:0] IR_CAPTURE_LOW = 2'h1;
    localparam logic IR_CAPTURE_HIGH = 1'h0;

    // Identification code; value is arbitrary, bit 0 set as convention asks
    localparam logic [ID_W-1:0] ID_CODE_DEFAULT = 32'h0A5A_5001;

    ////////////////////////////////////////////////////////////////////////////
    // Controller states
    typedef enum logic [3:0] {
        ST_RESET      = 4'h0,
        ST_IDLE       = 4'h1,
        ST_SEL_DR     = 4'h2,
        ST_CAPTURE_DR = 4'h3,
        ST_SHIFT_DR   = 4'h4,
        ST_EXIT1_DR   = 4'h5,
        ST_PAUSE_DR   = 4'h6,
        ST_EXIT2_DR   = 4'h7,
        ST_UPDATE_DR  = 4'h8,
        ST_SEL_IR     = 4'h9,
        ST_CAPTURE_IR = 4'hA,
        ST_SHIFT_IR   = 4'hB,
        ST_EXIT1_IR   = 4'hC,
        ST_PAUSE_IR   = 4'hD,
        ST_EXIT2_IR   = 4'hE,
        ST_UPDATE_IR  = 4'hF
    } tap_state_t;

    ////////////////////////////////////////////////////////////////////////////
    // Pin groups
    typedef struct packed {
        logic tck;
        logic tms;
        logic tdi;
    } tap_pins_t;

    typedef struct packed {
        logic tdo;
        logic tdo_oe;
    } tap_out_t;

    ////////////////////////////////////////////////////////////////////////////
    // Whole state of the port core
    typedef struct packed {
        logic tck_prev;
        tap_state_t state;
        logic [IR_W-1:0] ir;
        logic [IR_W-1:0] ir_sh;
        logic bypass;
        logic [BSR_LEN-1:0] bsr;
        logic [ID_W-1:0] id_sh;
        logic tdo;
        logic tdo_oe;
        logic ring_hiz;
    } tap_core_t;

    // Value after reset
    localparam tap_core_t CORE_RST = '{
        tck_prev: 1'h0,
        state: ST_RESET,
        ir: INS_IDCODE,
        ir_sh: INS_IDCODE,
        bypass: 1'h0,
        bsr: '0,
        id_sh: '0,
        tdo: 1'h0,
        tdo_oe: 1'h0,
        ring_hiz: 1'h0
    };

endpackage : tap_pkg

// file: hw/sync_2ff.sv
// Two flip-flop synchroniser for a group of asynchronous levels.
// Assumes the levels change slowly against i_clk.
`timescale 1ns/10ps
module sync_2ff #(
    parameter int unsigned W = 1
) (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_sys_rst,
    // Levels
    input wire logic [W-1:0] i_async,
    output logic [W-1:0] o_sync
);

    typedef struct packed {
        logic [W-1:0] s2;
        logic [W-1:0] s1;
    } sync_state_t;

    sync_state_t st_q;
    sync_state_t st_d;

    // First stage feeds only the second
    always_comb
    begin
        st_d.s1 = i_async;
        st_d.s2 = st_q.s1;
    end

    // Register the pair
    always_ff @(posedge i_clk or posedge i_sys_rst)
    begin
        if (i_sys_rst)
        begin
            st_q <= '0;
        end
        else
        begin
            st_q <= st_d;
        end
    end

    assign o_sync = st_q.s2;

endmodule : sync_2ff

// file: hw/tap_port.sv
// Serial boundary-scan test port: controller, instruction, bypass,
// identification and boundary scan registers, all stepped by test clock edges
// found by sampling the test clock with i_clk.
// Assumes the test clock is far slower than i_clk and the I/O ring value
// i_ring is on the i_clk domain. Pull-ups on mode-select and data-in are
// outside this module; an open pin must arrive here as 1.
// Reserved instruction codes select the bypass bit.
// Update-DR has no effect: nothing is ever preloaded onto the ring.
//
// Function
// - Inputs taken on test-clock rise; outputs launched on test-clock fall.
// - Mode-select steers controller on each rise; open pin reads high.
// - Data-in, pulled up, enters MSB of the selected scan register.
// - Data-out changes only on falls and shows the selected register LSB.
// - Data-out enable follows the controller state.
// - Five rises with mode-select high reset the port, memory undisturbed.
// - Power-up resets the port so data-out starts high impedance.
// - Loaded instruction selects exactly one scan register at a time.
// - Instruction register is three bits, loaded serially through data-in.
// - Instruction register shifts only in the instruction-shift path.
// - Identification instruction loaded at power-up and on controller reset.
// - Capture-IR loads the two instruction LSBs with 01.
// - Bypass is one bit under the bypass instruction, cleared when executed.
// - Boundary scan register is 107 bits, one per input/bidirectional ball.
// - Capture-DR loads ring values into boundary register; Shift-DR shifts it.
// - EXTEST, SAMPLE/PRELOAD and high-impedance sample all capture the ring.
// - Controller follows the standard state transitions, compatible in chains.
// - Identification instruction captures a fixed 32-bit code, shifted out.
// - High-impedance sample selects boundary register and floats memory outputs.
// - All-zero instruction acts like sample, memory outputs stay driven.
// - Update-DR under sample acts like a pause; no preload.
`timescale 1ns/10ps
module tap_port #(
    parameter logic [tap_pkg::ID_W-1:0] ID_CODE = tap_pkg::ID_CODE_DEFAULT
) (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_sys_rst,
    // Test pins from the scan controller
    input wire tap_pkg::tap_pins_t i_pins,
    // Memory I/O ring
    input wire logic [tap_pkg::BSR_LEN-1:0] i_ring,
    output logic o_ring_hiz,
    // Serial data out, three-state
    output logic o_tdo,
    output logic o_tdo_oe
);

    ////////////////////////////////////////////////////////////////////////////
    // Pin synchronisation

    tap_pkg::tap_pins_t pins_s;

    // All three pins cross together so they stay aligned
    // Shared delay keeps mode-select and data-in lined up with the clock edge
    sync_2ff #(
        .W(tap_pkg::PIN_W)
    ) u_pin_sync (
        .i_clk(i_clk),
        .i_sys_rst(i_sys_rst),
        .i_async(i_pins),
        .o_sync(pins_s)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Controller next state

    // Every state has both successors; five high rises end in reset from anywhere
    function automatic tap_pkg::tap_state_t next_state(
        input tap_pkg::tap_state_t cur,
        input logic tms
    );
        tap_pkg::tap_state_t nxt;
        nxt = cur;
        unique case (cur)
            tap_pkg::ST_RESET:
                nxt = tms ? tap_pkg::ST_RESET : tap_pkg::ST_IDLE;
            tap_pkg::ST_IDLE:
                nxt = tms ? tap_pkg::ST_SEL_DR : tap_pkg::ST_IDLE;
            tap_pkg::ST_SEL_DR:
                nxt = tms ? tap_pkg::ST_SEL_IR : tap_pkg::ST_CAPTURE_DR;
            tap_pkg::ST_CAPTURE_DR:
                nxt = tms ? tap_pkg::ST_EXIT1_DR : tap_pkg::ST_SHIFT_DR;
            tap_pkg::ST_SHIFT_DR:
                nxt = tms ? tap_pkg::ST_EXIT1_DR : tap_pkg::ST_SHIFT_DR;
            tap_pkg::ST_EXIT1_DR:
                nxt = tms ? tap_pkg::ST_UPDATE_DR : tap_pkg::ST_PAUSE_DR;
            tap_pkg::ST_PAUSE_DR:
                nxt = tms ? tap_pkg::ST_EXIT2_DR : tap_pkg::ST_PAUSE_DR;
            tap_pkg::ST_EXIT2_DR:
                nxt = tms ? tap_pkg::ST_UPDATE_DR : tap_pkg::ST_SHIFT_DR;
            tap_pkg::ST_UPDATE_DR:
                nxt = tms ? tap_pkg::ST_SEL_DR : tap_pkg::ST_IDLE;
            tap_pkg::ST_SEL_IR:
                nxt = tms ? tap_pkg::ST_RESET : tap_pkg::ST_CAPTURE_IR;
            tap_pkg::ST_CAPTURE_IR:
                nxt = tms ? tap_pkg::ST_EXIT1_IR : tap_pkg::ST_SHIFT_IR;
            tap_pkg::ST_SHIFT_IR:
                nxt = tms ? tap_pkg::ST_EXIT1_IR : tap_pkg::ST_SHIFT_IR;
            tap_pkg::ST_EXIT1_IR:
                nxt = tms ? tap_pkg::ST_UPDATE_IR : tap_pkg::ST_PAUSE_IR;
            tap_pkg::ST_PAUSE_IR:
                nxt = tms ? tap_pkg::ST_EXIT2_IR : tap_pkg::ST_PAUSE_IR;
            tap_pkg::ST_EXIT2_IR:
                nxt = tms ? tap_pkg::ST_UPDATE_IR : tap_pkg::ST_SHIFT_IR;
            tap_pkg::ST_UPDATE_IR:
                nxt = tms ? tap_pkg::ST_SEL_DR : tap_pkg::ST_IDLE;
        endcase
        return nxt;
    endfunction : next_state

    ////////////////////////////////////////////////////////////////////////////
    // Local constants

    // Top instruction bit loaded in Capture-IR
    localparam logic IR_HIGH = tap_pkg::IR_CAPTURE_HIGH;

    ////////////////////////////////////////////////////////////////////////////
    // Instruction decode

    // Ring capture instructions; reserved codes fall to bypass
    function automatic logic is_ring_ins(input logic [tap_pkg::IR_W-1:0] ins);
        return (ins == tap_pkg::INS_EXTEST) || (ins == tap_pkg::INS_SAMPLE)
            || (ins == tap_pkg::INS_SAMPLE_Z);
    endfunction : is_ring_ins

    ////////////////////////////////////////////////////////////////////////////
    // State

    tap_pkg::tap_core_t st_q;
    tap_pkg::tap_core_t st_d;
    logic tck_rise;
    logic tck_fall;
    logic sel_lsb;
    logic sel_id;
    logic sel_ring;

    // Test clock edges seen by i_clk
    // Edge memory resets low like the idle test clock, so no false edge
    assign tck_rise = pins_s.tck & ~st_q.tck_prev;
    assign tck_fall = ~pins_s.tck & st_q.tck_prev;

    // One data register is chosen by the loaded instruction
    always_comb
    begin
        sel_id = 1'h0;
        sel_ring = 1'h0;
        if (st_q.ir == tap_pkg::INS_IDCODE)
        begin
            sel_id = 1'h1;
        end
        else if (is_ring_ins(st_q.ir))
        begin
            sel_ring = 1'h1;
        end
    end

    // Bit presented by the one selected register
    always_comb
    begin
        if (st_q.state == tap_pkg::ST_SHIFT_IR)
        begin
            sel_lsb = st_q.ir_sh[0];
        end
        else if (sel_id)
        begin
            sel_lsb = st_q.id_sh[0];
        end
        else if (sel_ring)
        begin
            sel_lsb = st_q.bsr[0];
        end
        else
        begin
            sel_lsb = st_q.bypass;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Next value of the whole state

    always_comb
    begin
        st_d = st_q;
        st_d.tck_prev = pins_s.tck;

        // Rising edge: sample mode-select and data-in
        if (tck_rise)
        begin
            st_d.state = next_state(st_q.state, pins_s.tms);
            unique case (st_q.state)
                tap_pkg::ST_RESET:
                begin
                    st_d.ir = tap_pkg::INS_IDCODE;
                end
                tap_pkg::ST_CAPTURE_IR:
                begin
                    st_d.ir_sh = {IR_HIGH, tap_pkg::IR_CAPTURE_LOW};
                end
                tap_pkg::ST_SHIFT_IR:
                begin
                    st_d.ir_sh = {pins_s.tdi, st_q.ir_sh[tap_pkg::IR_W-1:1]};
                end
                tap_pkg::ST_CAPTURE_DR:
                begin
                    if (sel_id)
                    begin
                        st_d.id_sh = ID_CODE;
                    end
                    else if (sel_ring)
                    begin
                        // Ring is on i_clk, taken as it stands at the rise
                        st_d.bsr = i_ring;
                    end
                    else
                    begin
                        st_d.bypass = 1'h0;
                    end
                end
                tap_pkg::ST_SHIFT_DR:
                begin
                    if (sel_id)
                    begin
                        st_d.id_sh = {pins_s.tdi, st_q.id_sh[tap_pkg::ID_W-1:1]};
                    end
                    else if (sel_ring)
                    begin
                        st_d.bsr = {pins_s.tdi, st_q.bsr[tap_pkg::BSR_LEN-1:1]};
                    end
                    else
                    begin
                        st_d.bypass = pins_s.tdi;
                    end
                end
                tap_pkg::ST_UPDATE_DR:
                begin
                    // Update-DR drives nothing: no preload path exists
                    st_d.ir = st_q.ir;
                end
                tap_pkg::ST_IDLE,
                tap_pkg::ST_SEL_DR,
                tap_pkg::ST_EXIT1_DR,
                tap_pkg::ST_PAUSE_DR,
                tap_pkg::ST_EXIT2_DR,
                tap_pkg::ST_SEL_IR,
                tap_pkg::ST_EXIT1_IR,
                tap_pkg::ST_PAUSE_IR,
                tap_pkg::ST_EXIT2_IR,
                tap_pkg::ST_UPDATE_IR:
                begin
                    // Walk states keep every register
                    st_d.ir = st_q.ir;
                end
            endcase
        end

        // Falling edge: launch outputs, commit a new instruction
        if (tck_fall)
        begin
            // Data-out shows the bit left by the last rise
            st_d.tdo = sel_lsb;
            // Enable follows the state entered at the last rise
            st_d.tdo_oe = (st_q.state == tap_pkg::ST_SHIFT_IR)
                || (st_q.state == tap_pkg::ST_SHIFT_DR);
            // New instruction settles half a period before the next rise
            if (st_q.state == tap_pkg::ST_UPDATE_IR)
            begin
                st_d.ir = st_q.ir_sh;
            end
            else if (st_q.state == tap_pkg::ST_RESET)
            begin
                st_d.ir = tap_pkg::INS_IDCODE;
            end
        end

        // Only the high-impedance sample floats memory outputs
        st_d.ring_hiz = (st_q.ir == tap_pkg::INS_SAMPLE_Z);
    end

    ////////////////////////////////////////////////////////////////////////////
    // State register

    // Whole state resets together; data-out starts disabled
    always_ff @(posedge i_clk or posedge i_sys_rst)
    begin
        if (i_sys_rst)
        begin
            st_q <= tap_pkg::CORE_RST;
        end
        else
        begin
            st_q <= st_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Outputs

    assign o_tdo = st_q.tdo;
    assign o_tdo_oe = st_q.tdo_oe;
    assign o_ring_hiz = st_q.ring_hiz;

endmodule : tap_port

// file: bench/tap_port_asserts.sv
// Checker for the test port, watching only its ports.
// Assumes the test pins change on i_clk falling edges.
`timescale 1ns/10ps
module tap_port_asserts (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_sys_rst,
    // Test pins and ring
    input wire tap_pkg::tap_pins_t i_pins,
    input wire logic [tap_pkg::BSR_LEN-1:0] i_ring,
    // Outputs
    input wire logic o_ring_hiz,
    input wire logic o_tdo,
    input wire logic o_tdo_oe
);
    logic tck_q;
    logic tms_q;
    logic [2:0] since_q;
    logic [2:0] hi_q;
    logic [2:0] fall_q;

    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (i_sys_rst);

    //////////////////////////////////////////
    // Test-clock edges, mode-select history, time since the last fall
    always_ff @(posedge i_clk or posedge i_sys_rst)
    begin
        if (i_sys_rst)
        begin
            tck_q <= 1'h0;
            tms_q <= 1'h1;
            since_q <= 3'h7;
            hi_q <= 3'h0;
            fall_q <= 3'h0;
        end
        else
        begin
            tck_q <= i_pins.tck;
            if (i_pins.tck && !tck_q)
            begin
                tms_q <= i_pins.tms;
                hi_q <= !i_pins.tms ? 3'h0 : (hi_q == 3'h7 ? hi_q : hi_q + 3'h1);
            end
            if (!i_pins.tck && tck_q)
            begin
                since_q <= 3'h0;
                fall_q <= hi_q;
            end
            else if (since_q != 3'h7)
            begin
                since_q <= since_q + 3'h1;
            end
        end
    end

    //////////////////////////////////////////
    // Output timing and state checks
    tdo_on_fall_a: assert property ($changed(o_tdo) |-> since_q inside {[3'h1:3'h4]})
        else $error("data-out changed away from a test-clock fall");
    oe_enter_a: assert property ($rose(o_tdo_oe) |-> !tms_q && since_q inside {[3'h1:3'h4]})
        else $error("data-out enabled outside a shift entry");
    oe_leave_a: assert property ($fell(o_tdo_oe) |-> tms_q && since_q inside {[3'h1:3'h4]})
        else $error("data-out disabled outside a shift exit");
    oe_off_a: assert property (since_q == 3'h2 && tms_q |-> !o_tdo_oe)
        else $error("data-out driven after mode-select high");
    hiz_change_a: assert property ($changed(o_ring_hiz) |-> tms_q && since_q inside {[3'h1:3'h5]})
        else $error("ring float changed outside an update");
    tap_reset_a: assert property (since_q == 3'h6 && fall_q >= 3'h5 |-> !o_tdo_oe && !o_ring_hiz)
        else $error("five high mode-selects did not reset the port");
    power_up_a: assert property ($fell(i_sys_rst) |-> !o_tdo_oe && !o_tdo && !o_ring_hiz)
        else $error("outputs not idle after reset");
    tdo_hold_a: assert property (since_q == 3'h7 |-> $stable(o_tdo))
        else $error("data-out moved while test clock was steady");

    // Main scenarios
    shift_c: cover property ($rose(o_tdo_oe));
    float_c: cover property ($rose(o_ring_hiz));
    reset_c: cover property (since_q == 3'h6 && fall_q >= 3'h5);
endmodule : tap_port_asserts

bind tap_port tap_port_asserts u_chk (.i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_pins(i_pins),
    .i_ring(i_ring), .o_ring_hiz(o_ring_hiz), .o_tdo(o_tdo), .o_tdo_oe(o_tdo_oe));

// file: bench/scan_ctl.sv
// Model of the board scan controller driving the test pins.
// Assumes calls start on an i_clk falling edge; test clock is 8 clocks.
`timescale 1ns/10ps
module scan_ctl (
    // Clock
    input wire logic i_clk,
    // Data-out wire
    input wire logic i_tdo_line,
    // Test pins
    output tap_pkg::tap_pins_t o_pins
);
    // Idle pins: test clock low, open inputs read high
    initial
    begin
        o_pins = '{tck: 1'h0, tms: 1'h1, tdi: 1'h1};
    end

    // One test-clock period; returns data-out seen just before the rise
    task automatic step(input logic tms, input logic tdi, output logic tdo);
        o_pins.tms = tms;
        o_pins.tdi = tdi;
        repeat (4) @(negedge i_clk);
        tdo = i_tdo_line;
        o_pins.tck = 1'h1;
        repeat (4) @(negedge i_clk);
        o_pins.tck = 1'h0;
    endtask : step

    // Five high mode-selects, then on to idle
    task automatic to_idle;
        logic t;
        repeat (5) step(1'h1, 1'h1, t);
        step(1'h0, 1'h1, t);
    endtask : to_idle
endmodule : scan_ctl

// file: bench/test_sram_jtag_tap.sv
// Bench for the test port: scans every register through the pins.
// Assumes the scan controller model owns the test pins.
`timescale 1ns/10ps
module test_sram_jtag_tap;
    localparam logic [31:0] ID = 32'h0C3C_3001; // Arbitrary identification value
    logic clk = 1'h0;
    logic rst = 1'h1;
    logic [106:0] ring = '0;
    tap_pkg::tap_pins_t pins;
    logic hiz;
    logic tdo;
    logic oe;
    wire logic tdo_line;
    int error_cnt = 0;
    int num_checks = 0;
    int cycles = 0;
    logic [127:0] d;
    logic t;

    // Released data-out shows the opposite of its last value
    assign tdo_line = oe ? tdo : ~tdo;

    // Clock and hang limit
    always #4 clk = ~clk;
    always @(posedge clk)
    begin
        cycles <= cycles + 1;
        if (cycles == 30000)
        begin
            error_cnt++;
            report_and_stop();
        end
    end

    tap_port #(.ID_CODE(ID)) u_dut (.i_clk(clk), .i_sys_rst(rst), .i_pins(pins), .i_ring(ring),
        .o_ring_hiz(hiz), .o_tdo(tdo), .o_tdo_oe(oe));
    scan_ctl u_ctl (.i_clk(clk), .i_tdo_line(tdo_line), .o_pins(pins));

    //////////////////////////////////////////
    // Shared tasks
    task automatic check(input logic ok, input string what);
        num_checks++;
        if (ok !== 1'h1)
        begin
            error_cnt++;
            $display("BAD %0t %s", $time, what);
        end
    endtask : check

    task automatic scan(input logic ir, input int n, input logic [127:0] din,
        output logic [127:0] dout);
        logic x;
        dout = '0;
        u_ctl.step(1'h1, 1'h1, x);
        if (ir)
        begin
            u_ctl.step(1'h1, 1'h1, x);
        end
        u_ctl.step(1'h0, 1'h1, x);
        u_ctl.step(1'h0, 1'h1, x);
        for (int i = 0; i < n; i++)
        begin
            u_ctl.step(i == n - 1, din[i], dout[i]);
        end
        u_ctl.step(1'h1, 1'h1, x);
        u_ctl.step(1'h0, 1'h1, x);
    endtask : scan

    task automatic load(input logic [2:0] code);
        scan(1'h1, 3, {125'h0, code}, d);
        check(d[2:0] === 3'h1, "instruction capture pattern");
    endtask : load

    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0)
        begin
            $display("Simulation passed");
        end
        else
        begin
            $display("Simulation failed");
        end
        $finish;
    endtask : report_and_stop

    //////////////////////////////////////////
    // Scenarios
    task automatic t_idcode;
        check(oe === 1'h0 && hiz === 1'h0 && tdo === 1'h0, "outputs after reset");
        u_ctl.to_idle();
        scan(1'h0, 32, '0, d);
        check(d[31:0] === ID, "identification code");
        check(oe === 1'h0, "data-out idle");
        $display("done idcode");
    endtask : t_idcode

    task automatic t_bypass;
        load(tap_pkg::INS_BYPASS);
        scan(1'h0, 8, 128'hB4, d);
        check(d[7:0] === 8'h68, "bypass path");
        $display("done bypass");
    endtask : t_bypass

    task automatic t_ring;
        logic [2:0] codes [3] = '{tap_pkg::INS_EXTEST, tap_pkg::INS_SAMPLE, tap_pkg::INS_SAMPLE_Z};
        for (int k = 0; k < 3; k++)
        begin
            ring = {11'h5A3, {12{8'hC6 ^ 8'(k)}}};
            load(codes[k]);
            check(hiz === (codes[k] == tap_pkg::INS_SAMPLE_Z), "memory float");
            scan(1'h0, 110, {4{32'h9C3A_0F65}}, d);
            check(d[109:0] === {3'h5, ring}, "ring capture and length");
            scan(1'h0, 107, '0, d);
            check(d[106:0] === ring && hiz === (codes[k] == tap_pkg::INS_SAMPLE_Z),
                "update without preload");
        end
        $display("done ring");
    endtask : t_ring

    task automatic t_reset;
        load(tap_pkg::INS_SAMPLE_Z);
        check(hiz === 1'h1, "float before pin reset");
        for (int k = 0; k < 4; k++)
        begin
            u_ctl.step(k == 0, 1'h0, t);
        end
        u_ctl.to_idle();
        check(hiz === 1'h0 && oe === 1'h0, "pin reset");
        scan(1'h0, 32, '0, d);
        check(d[31:0] === ID, "identification after pin reset");
        load(tap_pkg::INS_SAMPLE_Z);
        check(hiz === 1'h1, "float before system reset");
        rst = 1'h1;
        repeat (2) @(negedge clk);
        rst = 1'h0;
        check(hiz === 1'h0 && oe === 1'h0, "system reset mid-run");
        $display("done reset");
    endtask : t_reset

    // Main sequence
    initial
    begin
        repeat (4) @(negedge clk);
        rst = 1'h0;
        repeat (3) @(negedge clk);
        t_idcode();
        t_bypass();
        t_ring();
        t_reset();
        report_and_stop();
    end
endmodule : test_sram_jtag_tap
